// ### hw/ulpi_upper_register_map.sv
// upper register bank: scratch byte, gaps, extended escape, power control
// assumes the ulpi front end has decoded one access per cycle; reg_ext
// marks an access that came through the extended escape
`timescale 1ns/100ps
`default_nettype none
module ulpi_upper_register_map
   import ulpi_upper_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register access from the link decoder
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_ext,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   // read answer
   output logic rd_valid,
   output logic [7:0] rd_data,
   // session comparator
   input wire logic bvalid,
   // rxcmd request toward the ulpi transmitter
   output logic alt_int_req,
   input wire logic alt_int_ack
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] scratch; // test byte, drives nothing
      logic [7:0] pwr_ctrl; // power control byte
      logic rd_valid; // read answer strobe
      logic [7:0] rd_data; // read answer data
      logic alt_int; // pending alt_int rxcmd
   } bank_st_t;
   bank_st_t st_ff, nxt_st;

   bvalid_edge_if eif ();

   // decide whether an access lands on an effective immediate address or nowhere
   function automatic logic eff_ok(input logic ext, input logic [7:0] a);
      // extended space folds 00h-3Fh onto immediate; 40h-FFh vanish
      eff_ok = (a <= ADDR_IMM_TOP) && (ext || (a != ADDR_EXT_ESCAPE));
   endfunction

   // which kind of write a given address is for a register triple
   function automatic acc_kind_t kind_of(input logic [7:0] a, input logic [7:0] base);
      if (a == base) begin
         kind_of = ACC_WRITE;
      end else if (a == base + 8'h01) begin
         kind_of = ACC_SET;
      end else if (a == base + 8'h02) begin
         kind_of = ACC_CLEAR;
      end else begin
         kind_of = ACC_NONE;
      end
   endfunction

   // apply write, set or clear to one byte
   function automatic logic [7:0] apply(input acc_kind_t k, input logic [7:0] cur,
                                        input logic [7:0] d);
      case (k)
         ACC_WRITE: apply = d;
         ACC_SET: apply = cur | d;
         ACC_CLEAR: apply = cur & ~d;
         default: apply = cur;
      endcase
   endfunction

   logic hit; // access lands in the immediate map
   acc_kind_t scr_kind; // scratch access kind
   acc_kind_t pwr_kind; // power control access kind

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      hit = eff_ok(reg_ext, reg_addr);
      scr_kind = hit ? kind_of(reg_addr, ADDR_SCRATCH) : ACC_NONE;
      pwr_kind = hit ? kind_of(reg_addr, ADDR_PWR_CTRL) : ACC_NONE;
      nxt_st = st_ff;
      // writes; gaps 19h-2Eh and other vendor slots fall through untouched
      if (reg_wr) begin
         nxt_st.scratch = apply(scr_kind, st_ff.scratch, reg_wdata);
         // reserved bits stored as written; the link keeps them zero
         nxt_st.pwr_ctrl = apply(pwr_kind, st_ff.pwr_ctrl, reg_wdata);
      end
      // read answer one cycle after the strobe; old data if written together
      nxt_st.rd_valid = reg_rd;
      nxt_st.rd_data = UNMAPPED_READ;
      if (reg_rd && scr_kind != ACC_NONE) begin
         nxt_st.rd_data = st_ff.scratch;
      end else if (reg_rd && pwr_kind != ACC_NONE) begin
         nxt_st.rd_data = st_ff.pwr_ctrl;
      end
      // pending alt_int: a new edge wins over the acknowledge
      if (alt_int_ack) begin
         nxt_st.alt_int = 1'b0;
      end
      if (eif.edge_evt) begin
         nxt_st.alt_int = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.scratch <= SCRATCH_RST;
         st_ff.pwr_ctrl <= PWR_CTRL_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // edge watcher hookup; scratch feeds nothing here
   // ----------------------------------------
   assign eif.rise_en = st_ff.pwr_ctrl[PWR_BVALID_RISE_BIT];
   assign eif.fall_en = st_ff.pwr_ctrl[PWR_BVALID_FALL_BIT];
   assign eif.bvalid = bvalid;

   bvalid_edge_watch u_watch (
      .clk(clk),
      .rst(rst),
      .eif(eif)
   );

   // outputs straight from the state flops
   assign rd_valid = st_ff.rd_valid;
   assign rd_data = st_ff.rd_data;
   assign alt_int_req = st_ff.alt_int;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_SCR_WRITE: assert property (@(posedge clk) disable iff (rst)
      reg_wr && eff_ok(reg_ext, reg_addr) && reg_addr == ADDR_SCRATCH
      ##1 reg_rd && !reg_wr && eff_ok(reg_ext, reg_addr) && reg_addr == ADDR_SCRATCH_CLR
      |=> rd_valid && rd_data == $past(reg_wdata, 2))
      else $error("scratch did not read back written value");
   AST_SCR_RESET: assert property (@(posedge clk)
      rst |=> st_ff.scratch == SCRATCH_RST)
      else $error("scratch not zero after reset");
   AST_SET_OR: assert property (@(posedge clk) disable iff (rst)
      reg_wr && eff_ok(reg_ext, reg_addr) && reg_addr == ADDR_PWR_CTRL_SET
      |=> st_ff.pwr_ctrl == ($past(st_ff.pwr_ctrl) | $past(reg_wdata)))
      else $error("set did not or data in");
   AST_CLR_AND: assert property (@(posedge clk) disable iff (rst)
      reg_wr && eff_ok(reg_ext, reg_addr) && reg_addr == ADDR_SCRATCH_CLR
      |=> st_ff.scratch == ($past(st_ff.scratch) & ~$past(reg_wdata)))
      else $error("clear did not remove ones");
   AST_GAP_QUIET: assert property (@(posedge clk) disable iff (rst)
      reg_wr && !reg_ext && reg_addr >= ADDR_UNIMPL_LO && reg_addr <= ADDR_UNIMPL_HI
      |=> $stable(st_ff.scratch) && $stable(st_ff.pwr_ctrl))
      else $error("gap write changed a register");
   AST_ESCAPE_EMPTY: assert property (@(posedge clk) disable iff (rst)
      reg_rd && !reg_ext && reg_addr == ADDR_EXT_ESCAPE |=> rd_data == UNMAPPED_READ)
      else $error("escape address returned data");
   AST_EXT_HIGH_QUIET: assert property (@(posedge clk) disable iff (rst)
      reg_ext && reg_addr > ADDR_IMM_TOP
      |=> $stable(st_ff.scratch) && $stable(st_ff.pwr_ctrl) && rd_data == UNMAPPED_READ)
      else $error("extended high address had an effect");
   AST_EXT_ALIAS: assert property (@(posedge clk) disable iff (rst)
      reg_wr && reg_ext && reg_addr == ADDR_PWR_CTRL |=> st_ff.pwr_ctrl == $past(reg_wdata))
      else $error("extended alias missed power control");
   AST_PWR_READ: assert property (@(posedge clk) disable iff (rst)
      reg_rd && !reg_wr && !reg_ext && reg_addr == ADDR_PWR_CTRL_CLR
      |=> rd_data == st_ff.pwr_ctrl)
      else $error("power control read mismatch");
   AST_ALT_HOLD: assert property (@(posedge clk) disable iff (rst)
      alt_int_req && !alt_int_ack |=> alt_int_req)
      else $error("alt_int request dropped without ack");
   AST_EDGE_TO_REQ: assert property (@(posedge clk) disable iff (rst)
      st_ff.pwr_ctrl[PWR_BVALID_RISE_BIT] && $rose(bvalid) && !$past(rst) ##1 1'b1
      |=> alt_int_req)
      else $error("rise did not raise alt_int");
   // read strobe answers in exactly one cycle, idle cycles read 00h
   AST_RD_STROBE: assert property (@(posedge clk) disable iff (rst)
      reg_rd |=> rd_valid)
      else $error("read strobe gave no answer");
   AST_RD_IDLE: assert property (@(posedge clk) disable iff (rst)
      !reg_rd |=> !rd_valid && rd_data == UNMAPPED_READ)
      else $error("read answer outside a read");
   // the other halves of write, set and clear on both bytes
   AST_SCR_SET_OR: assert property (@(posedge clk) disable iff (rst)
      reg_wr && eff_ok(reg_ext, reg_addr) && reg_addr == ADDR_SCRATCH_SET
      |=> st_ff.scratch == ($past(st_ff.scratch) | $past(reg_wdata)))
      else $error("scratch set did not or data in");
   AST_PWR_CLR_AND: assert property (@(posedge clk) disable iff (rst)
      reg_wr && eff_ok(reg_ext, reg_addr) && reg_addr == ADDR_PWR_CTRL_CLR
      |=> st_ff.pwr_ctrl == ($past(st_ff.pwr_ctrl) & ~$past(reg_wdata)))
      else $error("power control clear did not remove ones");
   AST_PWR_WRITE: assert property (@(posedge clk) disable iff (rst)
      reg_wr && !reg_ext && reg_addr == ADDR_PWR_CTRL |=> st_ff.pwr_ctrl == $past(reg_wdata))
      else $error("power control write lost");
   // request handshake: ack clears unless a new edge lands, nothing rises unasked
   AST_ACK_CLEARS: assert property (@(posedge clk) disable iff (rst)
      alt_int_ack && !eif.edge_evt |=> !alt_int_req)
      else $error("ack did not clear alt_int request");
   AST_EVT_SETS: assert property (@(posedge clk) disable iff (rst)
      eif.edge_evt |=> alt_int_req)
      else $error("edge event did not raise alt_int");
   AST_REQ_NEEDS_EVT: assert property (@(posedge clk) disable iff (rst)
      !eif.edge_evt && !alt_int_req |=> !alt_int_req)
      else $error("alt_int request without an edge event");
   // every output and the control byte sit at their reset values after reset
   AST_RST_OUTS: assert property (@(posedge clk)
      rst |=> !rd_valid && rd_data == UNMAPPED_READ && !alt_int_req && st_ff.pwr_ctrl == PWR_CTRL_RST)
      else $error("outputs not at reset values");
   // main scenarios
   CVR_SCR_SET: cover property (@(posedge clk) disable iff (rst)
      reg_wr && reg_addr == ADDR_SCRATCH_SET);
   CVR_EXT_ACCESS: cover property (@(posedge clk) disable iff (rst)
      reg_ext && reg_rd && reg_addr == ADDR_SCRATCH);
   CVR_ALT_INT: cover property (@(posedge clk) disable iff (rst)
      alt_int_req && alt_int_ack);
   CVR_BACK_TO_BACK: cover property (@(posedge clk) disable iff (rst)
      reg_wr ##1 reg_rd);
   CVR_FALL_EVT: cover property (@(posedge clk) disable iff (rst)
      eif.edge_evt && !bvalid);
endmodule
`default_nettype wire

// ### common/ulpi_upper_pkg.sv
// constants for the upper register bank of a ulpi transceiver
// assumes the link decoder hands over one register access per cycle
package ulpi_upper_pkg;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_SCRATCH = 8'h16;
   localparam logic [7:0] ADDR_SCRATCH_SET = 8'h17;
   localparam logic [7:0] ADDR_SCRATCH_CLR = 8'h18;
   localparam logic [7:0] ADDR_UNIMPL_LO = 8'h19;
   localparam logic [7:0] ADDR_UNIMPL_HI = 8'h2E;
   localparam logic [7:0] ADDR_EXT_ESCAPE = 8'h2F;
   localparam logic [7:0] ADDR_VENDOR_LO = 8'h30;
   localparam logic [7:0] ADDR_PWR_CTRL = 8'h3D;
   localparam logic [7:0] ADDR_PWR_CTRL_SET = 8'h3E;
   localparam logic [7:0] ADDR_PWR_CTRL_CLR = 8'h3F;
   localparam logic [7:0] ADDR_IMM_TOP = 8'h3F;
   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int PWR_BVALID_FALL_BIT = 3;
   localparam int PWR_BVALID_RISE_BIT = 2;
   localparam logic [7:0] SCRATCH_RST = 8'h00;
   localparam logic [7:0] PWR_CTRL_RST = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // access kind decoded from the address
   typedef enum {ACC_NONE, ACC_WRITE, ACC_SET, ACC_CLEAR} acc_kind_t;
endpackage

// ### common/bvalid_edge_if.sv
// signals between the register bank and the b-session-valid edge watcher
// assumes both ends share clk
`timescale 1ns/100ps
`default_nettype none
interface bvalid_edge_if;
   logic rise_en; // report low-to-high
   logic fall_en; // report high-to-low
   logic bvalid; // session comparator level
   logic edge_evt; // one-cycle pulse, enabled edge seen
   modport bank (output rise_en, output fall_en, output bvalid, input edge_evt);
   modport watcher (input rise_en, input fall_en, input bvalid, output edge_evt);
endinterface
`default_nettype wire

// ### hw/bvalid_edge_watch.sv
// edge watcher on the b-session-valid level
// assumes bvalid is already synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module bvalid_edge_watch
   import ulpi_upper_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // link to the register bank
   bvalid_edge_if.watcher eif
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic primed; // first sample taken after reset
      logic prev; // bvalid one cycle ago
      logic evt; // registered event pulse
   } watch_st_t;
   watch_st_t st_ff, nxt_st;

   // compare against last sample; no edge before the first sample
   always_comb begin
      nxt_st = st_ff;
      nxt_st.primed = 1'b1;
      nxt_st.prev = eif.bvalid;
      nxt_st.evt = 1'b0;
      if (st_ff.primed) begin
         // falling edge, enabled
         if (st_ff.prev && !eif.bvalid && eif.fall_en) begin
            nxt_st.evt = 1'b1;
         end
         // rising edge, enabled
         if (!st_ff.prev && eif.bvalid && eif.rise_en) begin
            nxt_st.evt = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign eif.edge_evt = st_ff.evt;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_FALL_EVT: assert property (@(posedge clk) disable iff (rst)
      st_ff.primed && $fell(eif.bvalid) && eif.fall_en |=> eif.edge_evt)
      else $error("enabled bvalid fall gave no event");
   AST_RISE_EVT: assert property (@(posedge clk) disable iff (rst)
      st_ff.primed && $rose(eif.bvalid) && eif.rise_en |=> eif.edge_evt)
      else $error("enabled bvalid rise gave no event");
   AST_NO_SPURIOUS: assert property (@(posedge clk) disable iff (rst)
      $stable(eif.bvalid) |=> !eif.edge_evt)
      else $error("event without bvalid edge");
endmodule
`default_nettype wire

// ### bench/alt_int_link.sv
// link-side model that takes alt_int rxcmd requests and acknowledges them
// assumes clk is shared with the bank; the request is sampled and the ack driven at the falling edge
`timescale 1ns/100ps
`default_nettype none
module alt_int_link (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // answer pace: cycles of pending request before the ack
   input wire logic [3:0] ack_delay,
   // rxcmd handshake
   input wire logic alt_int_req,
   output logic alt_int_ack
);
   // -------------------------------------------------
   // ack pacing
   // -------------------------------------------------
   int wait_cnt; // cycles the request has stood
   initial begin
      alt_int_ack = 1'b0;
      wait_cnt = 0;
   end
   // one-cycle ack after ack_delay cycles; relies only on the rxcmd, not on a polled comparator
   always @(negedge clk) begin
      if (rst || !alt_int_req || alt_int_ack) begin
         // idle or ack just sent: drop it so each ack is a single pulse
         wait_cnt <= 0;
         alt_int_ack <= 1'b0;
      end else if (wait_cnt == int'(ack_delay)) begin
         alt_int_ack <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// ### bench/ulpi_upper_register_map_test.sv
// self-checking bench for the upper register bank and its alt_int request
// assumes the link model alt_int_link and a 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module ulpi_upper_register_map_test
   import ulpi_upper_pkg::*;
;
   // -------------------------------------------------
   // stimulus and observed signals
   // -------------------------------------------------
   logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_ext = 1'b0, bvalid = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [3:0] ack_delay = 4'h1; // partner pace, prompt by default
   wire logic rd_valid, alt_int_req, alt_int_ack;
   wire logic [7:0] rd_data;
   int num_errors = 0, cmp_count = 0;
   always #5 clk = ~clk;
   ulpi_upper_register_map dut_u (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ext(reg_ext),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .bvalid(bvalid),
      .alt_int_req(alt_int_req), .alt_int_ack(alt_int_ack));
   alt_int_link link_u (.clk(clk), .rst(rst), .ack_delay(ack_delay), .alt_int_req(alt_int_req),
      .alt_int_ack(alt_int_ack));
   // -------------------------------------------------
   // access tasks
   // -------------------------------------------------
   // one-cycle write strobe; a gap cycle follows so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic x);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      reg_ext = x;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   // read answer stands one cycle right after the taking edge
   task automatic rd(input logic [7:0] a, input logic x, input logic [7:0] exp);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      reg_ext = x;
      @(negedge clk);
      reg_rd = 1'b0;
      `CHK(rd_valid, 1'b1)
      `CHK(rd_data, exp)
   endtask
   // write then read in the very next cycle; the read must see the new byte
   task automatic wr_rd(input logic [7:0] aw, input logic [7:0] d, input logic [7:0] ar, input logic [7:0] exp);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = aw;
      reg_wdata = d;
      reg_ext = 1'b0;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      reg_addr = ar;
      @(negedge clk);
      reg_rd = 1'b0;
      `CHK(rd_valid, 1'b1)
      `CHK(rd_data, exp)
   endtask
   // move bvalid, then look at the request two edges after it was seen
   task automatic ev(input logic lvl, input logic exp);
      @(negedge clk);
      bvalid = lvl;
      repeat (3) @(negedge clk);
      `CHK(alt_int_req, exp)
      repeat (12) @(negedge clk); // long enough for the slowest partner pace
      `CHK(alt_int_req, 1'b0)
   endtask
   // -------------------------------------------------
   // scenarios
   // -------------------------------------------------
   task automatic t_reset();
      rd(ADDR_SCRATCH, 1'b0, 8'h00);
      rd(ADDR_PWR_CTRL, 1'b0, 8'h00);
      `CHK(alt_int_req, 1'b0)
   endtask
   task automatic t_scratch();
      wr_rd(ADDR_SCRATCH, 8'hC3, ADDR_SCRATCH_CLR, 8'hC3);
      wr(ADDR_SCRATCH, 8'hA5, 1'b0);
      for (int i = 8'h16; i <= 8'h18; i++) rd(i[7:0], 1'b0, 8'hA5);
      wr(ADDR_SCRATCH_SET, 8'h5A, 1'b0);
      rd(ADDR_SCRATCH, 1'b0, 8'hFF);
      wr(ADDR_SCRATCH_CLR, 8'h0F, 1'b0);
      rd(ADDR_SCRATCH_CLR, 1'b0, 8'hF0);
   endtask
   // gaps, escape and vendor space other than power control must stay empty
   task automatic t_holes();
      for (int i = 8'h19; i <= 8'h3C; i++) begin
         wr(i[7:0], 8'hFF, 1'b0);
         rd(i[7:0], 1'b0, 8'h00);
      end
      rd(ADDR_SCRATCH, 1'b0, 8'hF0);
      rd(ADDR_PWR_CTRL, 1'b0, 8'h00);
   endtask
   task automatic t_ext();
      wr(ADDR_SCRATCH, 8'h3C, 1'b1);
      rd(ADDR_SCRATCH, 1'b0, 8'h3C);
      wr(ADDR_PWR_CTRL_SET, 8'h04, 1'b1);
      rd(ADDR_PWR_CTRL, 1'b0, 8'h04);
      wr(ADDR_PWR_CTRL, 8'h08, 1'b1);
      rd(ADDR_PWR_CTRL_CLR, 1'b1, 8'h08);
      wr(ADDR_PWR_CTRL_CLR, 8'h08, 1'b1);
      for (int i = 8'h40; i <= 8'hFF; i++) begin
         wr(i[7:0], 8'hFF, 1'b1);
         rd(i[7:0], 1'b1, 8'h00);
      end
      rd(ADDR_SCRATCH, 1'b1, 8'h3C);
      rd(ADDR_PWR_CTRL, 1'b1, 8'h00);
   endtask
   // only bits 3 and 2 are ever written to power control
   task automatic t_pwr();
      wr(ADDR_PWR_CTRL, 8'h08, 1'b0);
      wr(ADDR_PWR_CTRL_SET, 8'h04, 1'b0);
      for (int i = 8'h3D; i <= 8'h3F; i++) rd(i[7:0], 1'b0, 8'h0C);
      wr(ADDR_PWR_CTRL_CLR, 8'h08, 1'b0);
      rd(ADDR_PWR_CTRL, 1'b0, 8'h04);
   endtask
   // each edge enable alone, prompt and slow partner, scratch must steer nothing
   task automatic t_events();
      ev(1'b1, 1'b1);
      ev(1'b0, 1'b0);
      wr(ADDR_PWR_CTRL, 8'h08, 1'b0);
      ev(1'b1, 1'b0);
      ack_delay = 4'h6;
      ev(1'b0, 1'b1);
      wr(ADDR_PWR_CTRL, 8'h00, 1'b0);
      wr(ADDR_SCRATCH, 8'hFF, 1'b0);
      ev(1'b1, 1'b0);
      ev(1'b0, 1'b0);
   endtask
   // -------------------------------------------------
   // verdict, main sequence and watchdog
   // -------------------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_scratch();
      t_holes();
      t_ext();
      t_pwr();
      t_events();
      report_and_stop();
   end
   // the sequence needs under 2000 cycles; ten times that means a hang
   initial begin
      #200us;
      num_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
